// file: rtl/c8g_params.svh
`ifndef C8G_PARAMS_SVH
`define C8G_PARAMS_SVH

// ----------------------------------------------------------------------------
// register map, page 0
// ----------------------------------------------------------------------------
`define C8G_PAGE_CFG          8'h00
`define C8G_ADDR_SOURCE_CFG   8'h5F
`define C8G_ADDR_VOLUME       8'h61
`define C8G_ADDR_GAIN_TRIM    8'h62
`define C8G_ADDR_PHASE_TRIM   8'h63
`define C8G_ADDR_PROC_CFG0    8'h6B

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define C8G_RST_SOURCE_CFG    8'h00
`define C8G_RST_VOLUME        8'hC9
`define C8G_RST_GAIN_TRIM     8'h80
`define C8G_RST_PHASE_TRIM    8'h00
`define C8G_RST_PROC_CFG0     8'h01

// ----------------------------------------------------------------------------
// field positions and writable masks
// ----------------------------------------------------------------------------
`define C8G_SRC_LSB           5
`define C8G_SRC_MSB           6
`define C8G_GTRIM_LSB         4
`define C8G_GTRIM_MSB         7
`define C8G_HPF_LSB           0
`define C8G_HPF_MSB           1
`define C8G_SUM_LSB           2
`define C8G_SUM_MSB           3
`define C8G_DECI_LSB          4
`define C8G_DECI_MSB          5
`define C8G_MASK_SOURCE_CFG   8'h60
`define C8G_MASK_GAIN_TRIM    8'hF0
`define C8G_MASK_PROC_CFG0    8'h3F

// ----------------------------------------------------------------------------
// gain code anchors and phase line depth
// ----------------------------------------------------------------------------
`define C8G_VOL_MUTE_CODE     8'h00
`define C8G_VOL_UNITY_CODE    9'h0C9
`define C8G_GTRIM_ZERO_CODE   5'h08
`define C8G_PHASE_MAX         256

`endif

// file: rtl/c8g_pkg.sv
package c8g_pkg;

  // --------------------------------------------------------------------------
  // mode encodings
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    C8G_DECI_LINEAR   = 2'h0,
    C8G_DECI_LOW_LAT  = 2'h1,
    C8G_DECI_ULOW_LAT = 2'h2,
    C8G_DECI_RSVD     = 2'h3
  } c8g_deci_t;

  typedef enum logic [1:0] {
    C8G_SUM_OFF   = 2'h0,
    C8G_SUM_PAIRS = 2'h1,
    C8G_SUM_QUAD  = 2'h2,
    C8G_SUM_RSVD  = 2'h3
  } c8g_sum_t;

  typedef enum logic [1:0] {
    C8G_HPF_PROG_IIR = 2'h0,
    C8G_HPF_FC_00025 = 2'h1,
    C8G_HPF_FC_002   = 2'h2,
    C8G_HPF_FC_008   = 2'h3
  } c8g_hpf_t;

  // --------------------------------------------------------------------------
  // register access request and decoded configuration
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } c8g_req_t;

  typedef struct packed {
    logic             source_valid;
    logic             mute;
    logic signed [8:0] volume_half_db;
    logic signed [4:0] trim_tenth_db;
    logic [7:0]       phase_delay;
    c8g_deci_t        deci;
    logic             deci_rsvd;
    c8g_sum_t         sum_mode;
    logic             sum_rsvd;
    c8g_hpf_t         hpf;
  } c8g_cfg_t;

endpackage

// file: rtl/c8g_phase_delay.sv
`timescale 1ns/1ps
`include "c8g_params.svh"

// delays a pulse-density bit stream by a programmable number of modulator ticks
module c8g_phase_delay #(
  parameter int DEPTH = `C8G_PHASE_MAX
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // stream in
  input  wire logic       mod_tick_i,
  input  wire logic       bit_i,
  input  wire logic [7:0] delay_i,
  // stream out
  output logic            bit_o
);

  // --------------------------------------------------------------------------
  // tap line
  // --------------------------------------------------------------------------
  logic [DEPTH-2:0] line_reg;
  logic [DEPTH-2:0] line_next;
  logic             tap;

  // tap 0 is the live bit, so code 0 means no added delay
  // the deepest code reads bit DEPTH-2, so the line stops there
  assign line_next = {line_reg[DEPTH-3:0], bit_i};
  assign tap       = (delay_i == 8'h00) ? bit_i : line_reg[delay_i - 8'h01];

  // shift only on modulator ticks; a whole tick period per step
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      line_reg <= '0;
    end else if (mod_tick_i) begin
      line_reg <= line_next;
    end
  end

  // output is registered, one system clock behind the tap
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bit_o <= 1'b0;
    end else begin
      bit_o <= tap;
    end
  end

endmodule

// file: rtl/c8g_top.sv
`timescale 1ns/1ps
`include "c8g_params.svh"

// ----------------------------------------------------------------------------
// channel 8 configuration bank
// ----------------------------------------------------------------------------
// Operation
// - source field bits 6:5, codes 0-2 pin4, 3 reserved
// - volume code zero mutes the channel
// - code1 -100dB, code2 -99.5dB, half-dB steps
// - code 201 unity, 255 +27dB, reset C9h
// - trim bits 7:4, -0.8..+0.7dB, reset 8
// - phase code delays that many modulator cycles
// - processing register 0x6B fields, reset 1h
// - decimator select linear, low, ultra-low, reserved
// - averaging off, pairs, quad, reserved
// - highpass programmable IIR or three fixed cutoffs
module c8g_top (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               sys_rst_i,
  // control port register access
  input  wire c8g_pkg::c8g_req_t  req_i,
  output logic [7:0]              rdata_o,
  output logic                    rvalid_o,
  // pulse-density input path
  input  wire logic               mod_tick_i,
  input  wire logic               pulse_data_input_4_i,
  output logic                    channel8_bit_o,
  // decoded configuration
  output c8g_pkg::c8g_cfg_t       cfg_o
);
  import c8g_pkg::*;

  // --------------------------------------------------------------------------
  // storage
  // --------------------------------------------------------------------------
  logic [7:0] channel8_source_cfg_reg;
  logic [7:0] channel8_volume_reg;
  logic [7:0] channel8_gain_trim_reg;
  logic [7:0] channel8_phase_trim_reg;
  logic [7:0] processing_config_0_reg;
  logic [7:0] rdata_next;
  logic       hit_page;
  logic       sel_src;
  logic       sel_vol;
  logic       sel_trim;
  logic       sel_phase;
  logic       sel_proc;
  c8g_cfg_t   cfg_next;
  logic       wr_src;
  logic       wr_vol;
  logic       wr_trim;
  logic       wr_phase;
  logic       wr_proc;
  logic [1:0] src_code;
  logic [3:0] trim_code;
  logic [1:0] deci_code;
  logic [1:0] sum_code;
  logic [1:0] hpf_code;

  // one-hot address match, used for both writes and reads
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ref_a);
    addr_is = (a == ref_a);
  endfunction

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  assign hit_page  = (req_i.page == `C8G_PAGE_CFG);
  assign sel_src   = hit_page && addr_is(req_i.addr, `C8G_ADDR_SOURCE_CFG);
  assign sel_vol   = hit_page && addr_is(req_i.addr, `C8G_ADDR_VOLUME);
  assign sel_trim  = hit_page && addr_is(req_i.addr, `C8G_ADDR_GAIN_TRIM);
  assign sel_phase = hit_page && addr_is(req_i.addr, `C8G_ADDR_PHASE_TRIM);
  assign sel_proc  = hit_page && addr_is(req_i.addr, `C8G_ADDR_PROC_CFG0);

  // write strobes, one per register; a write to another page never lands
  assign wr_src   = req_i.wr && sel_src;
  assign wr_vol   = req_i.wr && sel_vol;
  assign wr_trim  = req_i.wr && sel_trim;
  assign wr_phase = req_i.wr && sel_phase;
  assign wr_proc  = req_i.wr && sel_proc;

  // reserved bits are masked on write so they always read as zero
  // source register: only bits 6:5 hold, the rest stay zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      channel8_source_cfg_reg <= `C8G_RST_SOURCE_CFG;
    end else if (wr_src) begin
      channel8_source_cfg_reg <= req_i.wdata & `C8G_MASK_SOURCE_CFG;
    end
  end

  // volume register, full byte
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      channel8_volume_reg <= `C8G_RST_VOLUME;
    end else if (wr_vol) begin
      channel8_volume_reg <= req_i.wdata;
    end
  end

  // gain trim register: low nibble reserved
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      channel8_gain_trim_reg <= `C8G_RST_GAIN_TRIM;
    end else if (wr_trim) begin
      channel8_gain_trim_reg <= req_i.wdata & `C8G_MASK_GAIN_TRIM;
    end
  end

  // phase trim register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      channel8_phase_trim_reg <= `C8G_RST_PHASE_TRIM;
    end else if (wr_phase) begin
      channel8_phase_trim_reg <= req_i.wdata;
    end
  end

  // shared processing register: bits 7:6 reserved
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      processing_config_0_reg <= `C8G_RST_PROC_CFG0;
    end else if (wr_proc) begin
      processing_config_0_reg <= req_i.wdata & `C8G_MASK_PROC_CFG0;
    end
  end

  // --------------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------------
  // unmapped addresses and other pages read as zero
  assign rdata_next = ({8{sel_src}}   & channel8_source_cfg_reg)
                    | ({8{sel_vol}}   & channel8_volume_reg)
                    | ({8{sel_trim}}  & channel8_gain_trim_reg)
                    | ({8{sel_phase}} & channel8_phase_trim_reg)
                    | ({8{sel_proc}}  & processing_config_0_reg);

  // rvalid answers every read strobe, mapped or not, so the master never waits
  // read data held until the next read, so a slow serial port can shift it out
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.rd;
      if (req_i.rd) begin
        rdata_o <= rdata_next;
      end
    end
  end

  // --------------------------------------------------------------------------
  // decode to the processing path
  // --------------------------------------------------------------------------
  // field slices, so the decode below reads by name rather than bit position
  assign src_code  = channel8_source_cfg_reg[`C8G_SRC_MSB:`C8G_SRC_LSB];
  assign trim_code = channel8_gain_trim_reg[`C8G_GTRIM_MSB:`C8G_GTRIM_LSB];
  assign deci_code = processing_config_0_reg[`C8G_DECI_MSB:`C8G_DECI_LSB];
  assign sum_code  = processing_config_0_reg[`C8G_SUM_MSB:`C8G_SUM_LSB];
  assign hpf_code  = processing_config_0_reg[`C8G_HPF_MSB:`C8G_HPF_LSB];

  // gains leave as signed offsets from their zero-dB codes, so the gain stage
  // needs no table; a reserved code is flagged, never blocked, and software
  // still reads back what it wrote
  // only pin 4 feeds this channel; code 3 is flagged and the path keeps running
  assign cfg_next.source_valid =
    (src_code != 2'h3);
  assign cfg_next.mute = (channel8_volume_reg == `C8G_VOL_MUTE_CODE);
  // linear offset from unity: half-dB per code, 1 -> -200, 255 -> +54
  assign cfg_next.volume_half_db =
    $signed({1'b0, channel8_volume_reg} - `C8G_VOL_UNITY_CODE);
  // tenth-dB per code around code 8
  assign cfg_next.trim_tenth_db =
    $signed({1'b0, trim_code}
            - `C8G_GTRIM_ZERO_CODE);
  assign cfg_next.phase_delay = channel8_phase_trim_reg;
  assign cfg_next.deci =
    c8g_deci_t'(deci_code);
  assign cfg_next.deci_rsvd = (cfg_next.deci == C8G_DECI_RSVD);
  assign cfg_next.sum_mode =
    c8g_sum_t'(sum_code);
  assign cfg_next.sum_rsvd = (cfg_next.sum_mode == C8G_SUM_RSVD);
  assign cfg_next.hpf =
    c8g_hpf_t'(hpf_code);

  // decoded view registered so downstream sees glitch-free settings
  // the reset view matches the decode of the register reset values
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cfg_o <= '{source_valid:   1'b1,
                 mute:           1'b0,
                 volume_half_db: 9'sh000,
                 trim_tenth_db:  5'sh00,
                 phase_delay:    8'h00,
                 deci:           C8G_DECI_LINEAR,
                 deci_rsvd:      1'b0,
                 sum_mode:       C8G_SUM_OFF,
                 sum_rsvd:       1'b0,
                 hpf:            C8G_HPF_FC_00025};
    end else begin
      cfg_o <= cfg_next;
    end
  end

  // --------------------------------------------------------------------------
  // phase alignment of the microphone stream
  // --------------------------------------------------------------------------
  // the delay steps in whole modulator ticks; the tick, not the system clock,
  // sets the step, so a slow modulator clock still gets the full range
  c8g_phase_delay #(
    .DEPTH (`C8G_PHASE_MAX)
  ) i_c8g_phase_delay (
    .clk_i      (clk_i),
    .sys_rst_i  (sys_rst_i),
    .mod_tick_i (mod_tick_i),
    .bit_i      (pulse_data_input_4_i),
    .delay_i    (channel8_phase_trim_reg),
    .bit_o      (channel8_bit_o)
  );

endmodule

// file: tb/c8g_top_assertions.sv
`timescale 1ns/1ps
// ------------------------------------------------
// port checks for the channel 8 bank
// ------------------------------------------------
module c8g_top_assertions (
  // clock and reset
  input wire logic              clk_i,
  input wire logic              sys_rst_i,
  // register port
  input wire c8g_pkg::c8g_req_t req_i,
  input wire logic [7:0]        rdata_o,
  input wire logic              rvalid_o,
  // stream and decoded fields
  input wire logic              pulse_data_input_4_i,
  input wire logic              channel8_bit_o,
  input wire c8g_pkg::c8g_cfg_t cfg_o
);
  import c8g_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // decoded fields lag the write edge by two edges, hence ##2 below
  wire       w0 = req_i.wr && req_i.page == 8'h00;
  wire [7:0] wd = req_i.wdata;
  wire [7:0] ad = req_i.addr;
  property p_mute;
    w0 && ad == 8'h61 |-> ##2 cfg_o.mute == ($past(wd, 2) == 8'h00); endproperty
  a_mute: assert property (p_mute) else $error("mute flag wrong");
  property p_vol; w0 && ad == 8'h61 && wd != 8'h00 |->
    ##2 cfg_o.volume_half_db == $signed({1'b0, $past(wd, 2)}) - 9'sd201; endproperty
  a_vol: assert property (p_vol) else $error("volume step wrong");
  property p_trim; w0 && ad == 8'h62 |->
    ##2 cfg_o.trim_tenth_db == $signed({1'b0, $past(wd[7:4], 2)}) - 5'sd8; endproperty
  a_trim: assert property (p_trim) else $error("trim step wrong");
  property p_phase;
    w0 && ad == 8'h63 |-> ##2 cfg_o.phase_delay == $past(wd, 2); endproperty
  a_phase: assert property (p_phase) else $error("phase code wrong");
  property p_proc; w0 && ad == 8'h6B |-> ##2 {cfg_o.deci, cfg_o.sum_mode, cfg_o.hpf}
    == $past(wd[5:0], 2) && cfg_o.sum_rsvd == ($past(wd[3:2], 2) == 2'h3); endproperty
  a_proc: assert property (p_proc) else $error("processing fields wrong");
  property p_src; w0 && ad == 8'h5F |->
    ##2 cfg_o.source_valid == ($past(wd[6:5], 2) != 2'h3); endproperty
  a_src: assert property (p_src) else $error("source flag wrong");
  property p_rvalid; !$past(sys_rst_i) |-> rvalid_o == $past(req_i.rd); endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer timing wrong");
  property p_unmapped; req_i.rd && (req_i.page != 8'h00
    || !(ad inside {8'h5F, 8'h61, 8'h62, 8'h63, 8'h6B})) |=> rdata_o == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // zero code must pass the live bit with one clock of register delay only
  property p_nodelay; !$past(sys_rst_i) && cfg_o.phase_delay == 8'h00 && $past(cfg_o
    .phase_delay) == 8'h00 |-> channel8_bit_o == $past(pulse_data_input_4_i); endproperty
  a_nodelay: assert property (p_nodelay) else $error("zero delay path wrong");
  c_mute: cover property (w0 && ad == 8'h61 && wd == 8'h00);
  c_read: cover property (rvalid_o && rdata_o != 8'h00);
  c_bit: cover property ($rose(channel8_bit_o));
endmodule

bind c8g_top c8g_top_assertions i_c8g_top_assertions (.clk_i, .sys_rst_i, .req_i,
  .rdata_o, .rvalid_o, .pulse_data_input_4_i, .channel8_bit_o, .cfg_o);

// file: tb/c8g_top_test.sv
`timescale 1ns/1ps
// ------------------------------------------------
// bench for the channel 8 bank
// ------------------------------------------------
module c8g_top_test;
  import c8g_pkg::*;
  logic       clk_i      = 1'b0;
  logic       sys_rst_i  = 1'b1;
  logic       mod_tick_i = 1'b0;
  logic       pdm_bit    = 1'b0;
  c8g_req_t   req_i      = '0;
  logic [7:0] rdata_o;
  logic       rvalid_o;
  logic       channel8_bit_o;
  c8g_cfg_t   cfg_o;
  int         n_mismatch = 0;
  int         tests_run  = 0;
  int         cycles     = 0;

  always #50 clk_i = ~clk_i;

  c8g_top i_c8g_top (.clk_i, .sys_rst_i, .req_i, .rdata_o, .rvalid_o, .mod_tick_i,
    .pulse_data_input_4_i(pdm_bit), .channel8_bit_o, .cfg_o);

  // longest run is the 255 code stream, well under this ceiling
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic check(input string nm, input logic [8:0] exp, input logic [8:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // write pulse, then wait so the decoded fields have settled
  task automatic wr(input logic [7:0] pg, ad, d);
    @(negedge clk_i);
    req_i <= '{1'b1, 1'b0, pg, ad, d};
    @(negedge clk_i);
    req_i <= '0;
    @(negedge clk_i);
  endtask

  task automatic rd(input logic [7:0] pg, ad, exp);
    @(negedge clk_i);
    req_i <= '{1'b0, 1'b1, pg, ad, 8'h00};
    @(negedge clk_i);
    req_i <= '0;
    check("rvalid", 9'h001, {8'h00, rvalid_o});
    check("rdata", {1'b0, exp}, {1'b0, rdata_o});
  endtask

  task automatic t_regs();
    logic [7:0] ad [5] = '{8'h5F, 8'h61, 8'h62, 8'h63, 8'h6B};
    logic [7:0] rv [5] = '{8'h00, 8'hC9, 8'h80, 8'h00, 8'h01};
    logic [7:0] mk [5] = '{8'h60, 8'hFF, 8'hF0, 8'hFF, 8'h3F};
    // decoded view straight out of reset, before any write
    check("reset flags", 9'h002, {7'h00, cfg_o.source_valid, cfg_o.mute});
    check("reset volume", 9'h000, cfg_o.volume_half_db);
    check("reset trim", 9'h000, {4'h0, cfg_o.trim_tenth_db});
    check("reset proc", 9'h004, {1'b0, cfg_o.deci, cfg_o.sum_mode, cfg_o.hpf,
      cfg_o.deci_rsvd, cfg_o.sum_rsvd});
    for (int i = 0; i < 5; i++) begin
      rd(8'h00, ad[i], rv[i]);
      wr(8'h00, ad[i], 8'hFF);
      rd(8'h00, ad[i], mk[i]);
    end
    wr(8'h00, 8'h60, 8'h5A);
    rd(8'h00, 8'h60, 8'h00);
    wr(8'h01, 8'h61, 8'h00);
    rd(8'h00, 8'h61, 8'hFF);
    rd(8'h01, 8'h61, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_gain();
    logic [7:0] vc [6] = '{8'h00, 8'h01, 8'h02, 8'hC9, 8'hCA, 8'hFF};
    logic [8:0] vh [6] = '{9'h000, 9'h138, 9'h139, 9'h000, 9'h001, 9'h036};
    logic [3:0] tc [4] = '{4'h0, 4'h8, 4'h9, 4'hF};
    logic [4:0] th [4] = '{5'h18, 5'h00, 5'h01, 5'h07};
    for (int i = 0; i < 6; i++) begin
      wr(8'h00, 8'h61, vc[i]);
      check("mute", {8'h00, i == 0}, {8'h00, cfg_o.mute});
      if (i > 0)
        check("volume", vh[i], cfg_o.volume_half_db);
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 8'h62, {tc[i], 4'hF});
      check("trim", {4'h0, th[i]}, {4'h0, cfg_o.trim_tenth_db});
    end
    $display("test gain done");
  endtask

  task automatic t_modes();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wr(8'h00, 8'h6B, {2'h0, c, c, c});
      check("proc", {1'b0, c, c, c, c == 2'h3, c == 2'h3}, {1'b0, cfg_o.deci,
        cfg_o.sum_mode, cfg_o.hpf, cfg_o.deci_rsvd, cfg_o.sum_rsvd});
      wr(8'h00, 8'h5F, {1'b0, c, 5'h00});
      check("source", {8'h00, c != 2'h3}, {8'h00, cfg_o.source_valid});
    end
    $display("test modes done");
  endtask

  // a tick every sp clocks; sp above 1 shows the delay counts ticks, not clocks
  // just after tick j the output shows the bit taken at tick j - n
  task automatic t_phase(input logic [7:0] n, input int sp);
    logic hist [$];
    wr(8'h00, 8'h63, n);
    for (int j = 0; j < n + 40; j++) begin
      hist.push_back((j % 3 == 0) ^ (j % 7 == 1));
      pdm_bit    <= hist[j];
      mod_tick_i <= 1'b1;
      @(negedge clk_i);
      if (j >= n)
        check("delayed bit", {8'h00, hist[j - n]}, {8'h00, channel8_bit_o});
      if (sp > 1) begin
        mod_tick_i <= 1'b0;
        repeat (sp - 1) @(negedge clk_i);
      end
    end
    mod_tick_i <= 1'b0;
    $display("test phase %0d done", n);
  endtask

  initial begin
    repeat (2) @(negedge clk_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_gain();
    t_modes();
    t_phase(8'h03, 1);
    t_phase(8'hFF, 1);
    t_phase(8'h00, 1);
    t_phase(8'h05, 3);
    finish_test();
  end
endmodule
